/* rtl/bcb_defines.svh */
// constants for the button controlled boost pwm sequencer
// assumes a 250 MHz system clock and an active-low push button
`ifndef BCB_DEFINES_SVH
`define BCB_DEFINES_SVH

// clock rates in MHz
`define BCB_SYS_MHZ        250
`define BCB_SLOW_MHZ       8
// 8 MHz enable from a phase accumulator: adds 4 of 125 each clock
`define BCB_ACC_STEP       7'h04
`define BCB_ACC_MOD        7'h7D

// times and the oscillator rate in their own units
`define BCB_TICK_US        10000
`define BCB_OSC_KHZ        100
`define BCB_REF_PERIOD_US  508
`define BCB_REF_STEP_US    64
`define BCB_DEBOUNCE_MS    300
`define BCB_TICK_MS        10

// derived counts, all in 8 MHz enable pulses or in 10 ms ticks
`define BCB_TICK_COUNT     (`BCB_TICK_US * `BCB_SLOW_MHZ)
`define BCB_OSC_COUNT      ((`BCB_SLOW_MHZ * 1000) / `BCB_OSC_KHZ)
`define BCB_REF_COUNT      (`BCB_REF_PERIOD_US * `BCB_SLOW_MHZ)
`define BCB_REF_STEP       (`BCB_REF_STEP_US * `BCB_SLOW_MHZ)
`define BCB_DEBOUNCE_TICKS (`BCB_DEBOUNCE_MS / `BCB_TICK_MS)

// nested hold counters: 10 x 20 ticks of 10 ms gives 2 s
`define BCB_INNER_LOAD     4'hA
`define BCB_OUTER_LOAD     5'h14

// setpoint levels: 0 is 40 V, 5 is 15 V
`define BCB_LEVEL_TOP      3'h0
`define BCB_LEVEL_LAST     3'h5

// register offsets
`define BCB_ADDR_DUTY_HIGH 8'h00
`define BCB_ADDR_DUTY_CTRL 8'h04
`define BCB_ADDR_STATUS    8'h08
// reset values and field positions
`define BCB_DUTY_HIGH_RST  8'h0A
`define BCB_DUTY_CTRL_RST  8'h00
`define BCB_DUTY_LSB_HI    5
`define BCB_DUTY_LSB_LO    4

`endif

/* rtl/bcb_pkg.sv */
// types shared by the boost pwm sequencer
// assumes nothing beyond a SystemVerilog tool
package bcb_pkg;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    BCB_SLEEP   = 6'h01,
    BCB_WAKE    = 6'h02,
    BCB_RUN     = 6'h04,
    BCB_HOLD    = 6'h08,
    BCB_DEBNC   = 6'h10,
    BCB_RELEASE = 6'h20
  } bcb_state_t;
endpackage : bcb_pkg

/* rtl/bcb_top.sv */
// push-button boost sequencer: hold timing, setpoint stepping, two pwm outputs
// assumes one 250 MHz clock, a raw asynchronous button pin and a simple register port
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defines.svh"

module bcb_top #(
  parameter int TICK_DIV = `BCB_TICK_COUNT
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // button pin, low while pressed
  input  wire logic       button_in_n_i,
  // converter drive
  output logic            osc_pulse_out_o,
  output logic            reference_out_o,
  output logic            run_flag_o
);

  bcb_pkg::bcb_state_t state;
  bcb_pkg::bcb_state_t next_state;

  logic [6:0]  acc;
  logic        slow_en;
  logic [16:0] tick_cnt;
  logic        tick;
  logic        btn_meta;
  logic        btn_sync;
  logic        btn_last;
  logic        pressed;
  logic        changed;
  logic [3:0]  inner_hold_counter;
  logic [4:0]  outer_hold_counter;
  logic        long_hit;
  logic [4:0]  debounce_cnt;
  logic        run_flag;
  logic [2:0]  level;
  logic [7:0]  duty_high_byte;
  logic [7:0]  duty_control_field;
  logic [9:0]  duty;
  logic [6:0]  osc_cnt;
  logic [11:0] reference_timer;
  logic [11:0] ref_off;
  logic        measuring;

  // 8 MHz enable; 250/8 is not whole, so a phase accumulator keeps the average exact
  // the compare carries a spare bit, since acc plus the step can reach 128
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc     <= 7'h00;
      slow_en <= 1'b0;
    end else if ({1'b0, acc} + {1'b0, `BCB_ACC_STEP} >= {1'b0, `BCB_ACC_MOD}) begin
      acc     <= acc + `BCB_ACC_STEP - `BCB_ACC_MOD;
      slow_en <= 1'b1;
    end else begin
      acc     <= acc + `BCB_ACC_STEP;
      slow_en <= 1'b0;
    end
  end

  // 10 ms tick_timer built on the 8 MHz enable
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (slow_en) begin
        if (tick_cnt == 17'(TICK_DIV - 1)) begin
          tick_cnt <= 17'h00000;
          tick     <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 17'h00001;
        end
      end
    end
  end

  // button synchroniser; btn_meta feeds only btn_sync, all reset to the released level
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      btn_meta <= 1'b1;
      btn_sync <= 1'b1;
      btn_last <= 1'b1;
    end else begin
      btn_meta <= button_in_n_i;
      btn_sync <= btn_meta;
      btn_last <= btn_sync;
    end
  end

  assign pressed   = ~btn_sync;
  assign changed   = btn_sync ^ btn_last;
  assign measuring = (state == bcb_pkg::BCB_WAKE) || (state == bcb_pkg::BCB_HOLD);

  // nested hold counters, reloaded whenever no press is being timed
  always_ff @(posedge clock_i) begin
    if (rst_i || !measuring) begin
      inner_hold_counter <= `BCB_INNER_LOAD;
      outer_hold_counter <= `BCB_OUTER_LOAD;
      long_hit           <= 1'b0;
    end else if (tick && !long_hit) begin
      if (inner_hold_counter == 4'h1) begin
        inner_hold_counter <= `BCB_INNER_LOAD;
        if (outer_hold_counter == 5'h01) begin
          long_hit <= 1'b1; // 200 ticks reached
        end else begin
          outer_hold_counter <= outer_hold_counter - 5'h01;
        end
      end else begin
        inner_hold_counter <= inner_hold_counter - 4'h1;
      end
    end
  end

  // debounce counter runs in ticks only inside the debounce state
  always_ff @(posedge clock_i) begin
    if (rst_i || state != bcb_pkg::BCB_DEBNC) begin
      debounce_cnt <= 5'h00;
    end else if (tick) begin
      debounce_cnt <= debounce_cnt + 5'h01;
    end
  end

  // sequencer next-state logic
  always_comb begin
    next_state = state;
    case (state)
      bcb_pkg::BCB_SLEEP: begin
        if (changed && pressed) begin
          next_state = bcb_pkg::BCB_WAKE;
        end
      end
      bcb_pkg::BCB_WAKE: begin
        if (long_hit) begin
          next_state = bcb_pkg::BCB_RELEASE;
        end else if (!pressed) begin
          next_state = bcb_pkg::BCB_SLEEP;
        end
      end
      bcb_pkg::BCB_RUN: begin
        if (pressed) begin
          next_state = bcb_pkg::BCB_HOLD;
        end
      end
      bcb_pkg::BCB_HOLD: begin
        if (long_hit) begin
          next_state = bcb_pkg::BCB_RELEASE;
        end else if (!pressed) begin
          next_state = bcb_pkg::BCB_DEBNC;
        end
      end
      bcb_pkg::BCB_DEBNC: begin
        if (debounce_cnt == 5'(`BCB_DEBOUNCE_TICKS)) begin
          next_state = bcb_pkg::BCB_RUN;
        end
      end
      bcb_pkg::BCB_RELEASE: begin
        // wait out the long press so its release is not taken as a short press
        if (!pressed) begin
          next_state = run_flag ? bcb_pkg::BCB_RUN : bcb_pkg::BCB_SLEEP;
        end
      end
      default: begin
        next_state = bcb_pkg::BCB_SLEEP;
      end
    endcase
  end

  // state register; reset lands in sleep
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= bcb_pkg::BCB_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // run flag toggles only on a completed long press
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      run_flag <= 1'b0;
    end else if (state == bcb_pkg::BCB_WAKE && long_hit) begin
      run_flag <= 1'b1;
    end else if (state == bcb_pkg::BCB_HOLD && long_hit) begin
      run_flag <= 1'b0;
    end
  end

  // setpoint level: 0 is 40 V, each step is 5 V lower
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level <= `BCB_LEVEL_TOP;
    end else if (state == bcb_pkg::BCB_WAKE && long_hit) begin
      level <= `BCB_LEVEL_TOP;
    end else if (state == bcb_pkg::BCB_HOLD && !long_hit && !pressed) begin
      if (level == `BCB_LEVEL_LAST) begin
        level <= `BCB_LEVEL_TOP; // wrap 15 V to 40 V
      end else begin
        level <= level + 3'h1;
      end
    end
  end

  // duty registers, written over the register port
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      duty_high_byte     <= `BCB_DUTY_HIGH_RST;
      duty_control_field <= `BCB_DUTY_CTRL_RST;
    end else if (wr_i) begin
      if (addr_i == `BCB_ADDR_DUTY_HIGH) begin
        duty_high_byte <= wdata_i;
      end
      if (addr_i == `BCB_ADDR_DUTY_CTRL) begin
        duty_control_field <= wdata_i;
      end
    end
  end

  // only bits 5:4 of the control field reach the duty; others just store
  assign duty = {duty_high_byte,
                 duty_control_field[`BCB_DUTY_LSB_HI:`BCB_DUTY_LSB_LO]};

  // register read, data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `BCB_ADDR_DUTY_HIGH: rdata_o <= duty_high_byte;
        `BCB_ADDR_DUTY_CTRL: rdata_o <= duty_control_field;
        `BCB_ADDR_STATUS:    rdata_o <= {4'h0, level, run_flag};
        default:             rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // 100 kHz oscillator period counter, 80 slow enables long
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag) begin
      osc_cnt <= 7'h00;
    end else if (slow_en) begin
      if (osc_cnt == 7'(`BCB_OSC_COUNT - 1)) begin
        osc_cnt <= 7'h00;
      end else begin
        osc_cnt <= osc_cnt + 7'h01;
      end
    end
  end

  // 508 us reference_timer, independent of the oscillator counter
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag) begin
      reference_timer <= 12'h000;
    end else if (slow_en) begin
      if (reference_timer == 12'(`BCB_REF_COUNT - 1)) begin
        reference_timer <= 12'h000;
      end else begin
        reference_timer <= reference_timer + 12'h001;
      end
    end
  end

  // off-time grows by 64 us per step; product fits 12 bits for levels 0..5
  assign ref_off = 12'(level * `BCB_REF_STEP);

  // outputs from flip-flops, forced low while not running
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag) begin
      osc_pulse_out_o <= 1'b0;
      reference_out_o <= 1'b0;
    end else begin
      // a duty above the period just holds the pulse high
      osc_pulse_out_o <= ({3'h0, osc_cnt} < duty);
      // low for the off-time at the start of each period, then high
      reference_out_o <= (reference_timer >= ref_off);
    end
  end

  assign run_flag_o = run_flag;

endmodule : bcb_top
`default_nettype wire

/* bench/bcb_button_model.sv */
// push-button stand-in driving the sequencer's button pin
// assumes the bench raises press_i just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module bcb_button_model (
  // request from the bench
  input  wire logic press_i,
  // pin to the block, pulled up while released
  output logic      button_in_n_o
);
  // contact pulls to ground; the pull-up restores the idle level
  assign button_in_n_o = press_i ? 1'h0 : 1'h1;
endmodule : bcb_button_model
`default_nettype wire

/* bench/bcb_top_monitor.sv */
// concurrent checks on the boost sequencer ports
// assumes one clock domain and the bcb_top port list
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defines.svh"
module bcb_top_monitor #(
  parameter int TICK_DIV = 80000
) (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // pins
  input wire logic       button_in_n_i,
  input wire logic       osc_pulse_out_o,
  input wire logic       reference_out_o,
  input wire logic       run_flag_o
);
  // first tick may come early, so 199 ticks of at least 31 clocks per enable
  localparam int MIN_HOLD = 199 * TICK_DIV * 31;
  logic [31:0] hold_cnt;
  logic [31:0] per_cnt;
  logic        duty_wr;
  logic        duty_dirty;
  logic [31:0] low_cnt;
  logic [7:0]  duty_hi;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // raw pin hold length; the design sees the press a little later
  always_ff @(posedge clock_i) begin
    if (rst_i || button_in_n_i) hold_cnt <= 32'h0;
    else hold_cnt <= hold_cnt + 32'h1;
  end
  // a duty write can add one mid-period rise, so the two rises after it go unmeasured
  assign duty_wr = wr_i && (addr_i == `BCB_ADDR_DUTY_HIGH || addr_i == `BCB_ADDR_DUTY_CTRL);
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag_o) duty_dirty <= 1'h0;
    else if (duty_wr) duty_dirty <= 1'h1;
    else if ($rose(osc_pulse_out_o)) duty_dirty <= 1'h0;
  end
  // clocks since the last oscillator rise, cleared while stopped or after a duty write
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag_o) per_cnt <= 32'h0;
    else if ($rose(osc_pulse_out_o)) per_cnt <= (duty_dirty || duty_wr) ? 32'h0 : 32'h1;
    else if (duty_wr) per_cnt <= 32'h0;
    else if (per_cnt != 32'h0) per_cnt <= per_cnt + 32'h1;
  end
  // length of the current reference low stretch while running
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_flag_o || reference_out_o) low_cnt <= 32'h0;
    else low_cnt <= low_cnt + 32'h1;
  end
  // shadow of the duty high byte for readback
  always_ff @(posedge clock_i) begin
    if (rst_i) duty_hi <= `BCB_DUTY_HIGH_RST;
    else if (wr_i && addr_i == `BCB_ADDR_DUTY_HIGH) duty_hi <= wdata_i;
  end
  property p_wake_pressed;
    $rose(run_flag_o) |-> $past(button_in_n_i, 4) == 1'h0;
  endproperty
  a_wake_pressed: assert property (p_wake_pressed) else $error("run rose unpressed");
  property p_wake_hold;
    $rose(run_flag_o) |-> hold_cnt >= 32'(MIN_HOLD);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake on a short hold");
  property p_sleep_hold;
    $fell(run_flag_o) |-> hold_cnt >= 32'(MIN_HOLD);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep on a short hold");
  property p_osc_period;
    $rose(osc_pulse_out_o) && $past(run_flag_o) && per_cnt != 32'h0 |-> per_cnt == 32'h9C4;
  endproperty
  a_osc_period: assert property (p_osc_period) else $error("oscillator period wrong");
  property p_dark;
    !run_flag_o && !$past(run_flag_o) |-> !osc_pulse_out_o && !reference_out_o;
  endproperty
  a_dark: assert property (p_dark) else $error("outputs active while stopped");
  property p_status_rd;
    $past(rd_i) && $past(addr_i) == `BCB_ADDR_STATUS |-> rdata_o[0] == $past(run_flag_o);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status run bit wrong");
  property p_duty_rd;
    $past(rd_i) && $past(addr_i) == `BCB_ADDR_DUTY_HIGH |-> rdata_o == $past(duty_hi);
  endproperty
  a_duty_rd: assert property (p_duty_rd) else $error("duty high byte readback wrong");
  property p_ref_low;
    run_flag_o |-> low_cnt <= 32'h13882;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("reference low too long");
endmodule : bcb_top_monitor
bind bcb_top bcb_top_monitor #(.TICK_DIV(TICK_DIV)) u_mon (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .button_in_n_i(button_in_n_i),
  .osc_pulse_out_o(osc_pulse_out_o), .reference_out_o(reference_out_o),
  .run_flag_o(run_flag_o));
`default_nettype wire

/* bench/tb_bcb_top.sv */
// self-checking bench for the boost pwm sequencer
// assumes a reduced tick divider: one tick is 125 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_bcb_top;
  localparam int TD = 4;
  localparam int TK = 125;
  logic       clock_i = 1'h0;
  logic       rst_i   = 1'h1;
  logic [7:0] addr_i  = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i    = 1'h0;
  logic       rd_i    = 1'h0;
  logic       press   = 1'h0;
  logic [7:0] rdata_o;
  logic       btn_n;
  logic       osc;
  logic       vref;
  logic       run;
  int         n_errors = 0;
  int         compares = 0;
  // 250 MHz clock
  always #2 clock_i = ~clock_i;
  bcb_button_model u_btn (.press_i(press), .button_in_n_o(btn_n));
  bcb_top #(.TICK_DIV(TD)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .button_in_n_i(btn_n),
    .osc_pulse_out_o(osc), .reference_out_o(vref), .run_flag_o(run));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 chk(32'(rdata_o), 32'(exp));
  endtask : rdc
  task automatic hold(input int n);
    @(posedge clock_i);
    press <= 1'h1;
    repeat (n * TK) @(posedge clock_i);
    press <= 1'h0;
  endtask : hold
  // long press until the run flag reaches lvl; the hold length is judged
  task automatic long_press(input logic lvl);
    int n;
    @(posedge clock_i);
    press <= 1'h1;
    for (n = 0; n < 210 * TK && run !== lvl; n++) @(negedge clock_i);
    chk(32'(n >= 199 * TK && n <= 200 * TK + 8), 32'h1);
    @(posedge clock_i);
    press <= 1'h0;
    repeat (4 * TK) @(posedge clock_i);
  endtask : long_press
  task automatic t_regs();
    rdc(8'h00, 8'h0A);
    rdc(8'h04, 8'h00);
    rdc(8'h0C, 8'h00);
    wr(8'h04, 8'h3F);
    rdc(8'h04, 8'h3F);
    wr(8'h08, 8'hFF);
    rdc(8'h08, 8'h00);
  endtask : t_regs
  task automatic t_sleep_short();
    hold(20);
    repeat (10 * TK) @(posedge clock_i);
    rdc(8'h08, 8'h00);
    chk(32'({osc, vref}), 32'h0);
  endtask : t_sleep_short
  // osc period and high time with duty 63, reference held high at 40 V
  task automatic t_pwm();
    int h;
    int l;
    logic ok;
    wr(8'h00, 8'h0F);
    wr(8'h04, 8'h30);
    repeat (2) begin
      while (osc !== 1'h0) @(negedge clock_i);
      while (osc !== 1'h1) @(negedge clock_i);
    end
    ok = 1'h1;
    for (h = 0; osc === 1'h1; h++) begin
      ok &= vref;
      @(negedge clock_i);
    end
    for (l = 0; osc === 1'h0; l++) @(negedge clock_i);
    chk(32'(h >= 1967 && h <= 1970), 32'h1);
    chk(32'(h + l), 32'h9C4);
    chk(32'(ok), 32'h1);
  endtask : t_pwm
  // short presses step the level; a press inside the debounce is dropped
  task automatic t_steps();
    hold(4);
    repeat (3 * TK) @(posedge clock_i);
    hold(4);
    repeat (32 * TK) @(posedge clock_i);
    rdc(8'h08, 8'h03);
    // the first reference period outlasts this scenario, so every lower level
    // is still inside its off-time; back at 40 V the pin is high at once
    chk(32'(vref), 32'h0);
    for (int i = 2; i <= 6; i++) begin
      hold(4);
      repeat (32 * TK) @(posedge clock_i);
      rdc(8'h08, {4'h0, 3'(i % 6), 1'h1});
      chk(32'(vref), 32'(i % 6 == 0));
    end
  endtask : t_steps
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // watchdog a little above the expected 90k clocks, inside the run budget
  initial begin
    repeat (97000) @(posedge clock_i);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'h0;
    t_regs();
    t_sleep_short();
    long_press(1'h1);
    rdc(8'h08, 8'h01);
    t_pwm();
    t_steps();
    long_press(1'h0);
    chk(32'({osc, vref, run}), 32'h0);
    conclude();
  end
endmodule : tb_bcb_top
`default_nettype wire
